// ==== cfgss_dev.sv ====
// Device end: serial slave giving access to the configuration registers
`timescale 1ns/10ps
module cfgss_dev
  import cfgss_pkg::*;
(
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_I,
  cfgss_if.dev            bus,
  input  wire logic       BUS_ADDR_STRAP_I,
  output logic            WR_VALID_O,
  input  wire logic       WR_READY_I,
  output logic [7:0]      WR_ADDR_O,
  output logic [7:0]      WR_DATA_O,
  output logic [7:0]      RD_ADDR_O,
  input  wire logic [7:0] RD_DATA_I
);
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK} cfgss_dst_t;
  typedef enum logic [1:0] {K_DEV, K_REG, K_DAT} cfgss_kind_t;

  typedef struct packed {
    logic [1:0]              scl_s;
    logic [1:0]              sda_s;
    logic [1:0]              strap_s;
    logic [DEGLITCH_CYC-1:0] scl_h;
    logic [DEGLITCH_CYC-1:0] sda_d;
    logic                    scl_f;
    logic                    scl_fp;
    logic                    sda_f;
    logic                    sda_fp;
    cfgss_dst_t              st;
    cfgss_kind_t             kind;
    logic [3:0]              bitcnt;
    logic [7:0]              sh;
    logic                    rw;
    logic                    hack;
    logic [7:0]              ptr;
    logic                    sda_oe;
    logic                    push;
    logic [WR_WORD_W-1:0]    wdat;
  } cfgss_dev_t;

  cfgss_dev_t r, n;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       buf_ready;
  logic [WR_WORD_W-1:0] buf_out;

  // Pointer steps past the last register back to the first
  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    return p + 8'h01;
  endfunction

  // Filters start at the idle bus level, so no false edge follows reset
  localparam cfgss_dev_t D_RST = '{
    scl_s:   2'b11,
    sda_s:   2'b11,
    scl_h:   '1,
    sda_d:   '1,
    scl_f:   1'b1,
    scl_fp:  1'b1,
    sda_f:   1'b1,
    sda_fp:  1'b1,
    st:      S_IDLE,
    kind:    K_DEV,
    ptr:     PTR_RESET,
    default: '0
  };

  assign scl_rise = r.scl_f & ~r.scl_fp;
  assign scl_fall = ~r.scl_f & r.scl_fp;
  // Data is delayed as far as the clock, so a bit change after a falling
  // edge is never mistaken for a start or stop
  assign start_c  = r.scl_f & r.scl_fp & r.sda_fp & ~r.sda_f;
  assign stop_c   = r.scl_f & r.scl_fp & ~r.sda_fp & r.sda_f;

  assign bus.sda_oe_dev = r.sda_oe;
  assign RD_ADDR_O      = r.ptr;
  assign WR_ADDR_O      = buf_out[15:8];
  assign WR_DATA_O      = buf_out[7:0];

  // Holds written words while the register side stalls
  cfgss_buf #(
    .W     (WR_WORD_W),
    .DEPTH (WR_BUF_DEPTH)
  ) u_wbuf (
    .clk_i       (CORE_CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (r.push),
    .in_ready_o  (buf_ready),
    .in_data_i   (r.wdat),
    .out_valid_o (WR_VALID_O),
    .out_ready_i (WR_READY_I),
    .out_data_o  (buf_out)
  );

  always_comb begin
    n        = r;
    n.push   = 1'b0;
    n.scl_s  = {r.scl_s[0], bus.scl};
    n.sda_s  = {r.sda_s[0], bus.sda};
    n.strap_s = {r.strap_s[0], BUS_ADDR_STRAP_I};
    n.scl_h  = {r.scl_h[DEGLITCH_CYC-2:0], r.scl_s[1]};
    // A level change counts only once it has held for every tap
    if (&r.scl_h) begin
      n.scl_f = 1'b1;
    end else if (~|r.scl_h) begin
      n.scl_f = 1'b0;
    end
    n.scl_fp = r.scl_f;
    n.sda_d  = {r.sda_d[DEGLITCH_CYC-2:0], r.sda_s[1]};
    n.sda_f  = r.sda_d[DEGLITCH_CYC-1];
    n.sda_fp = r.sda_f;

    if (start_c) begin
      n.st     = S_RX;
      n.kind   = K_DEV;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st     = S_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (r.st)
        S_IDLE: begin
          n.sda_oe = 1'b0;
        end
        S_RX: begin
          if (scl_rise) begin
            n.sh     = {r.sh[6:0], r.sda_f};
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == BITS_PER_BYTE) begin
            n.bitcnt = '0;
            n.st     = S_ACK;
            n.sda_oe = 1'b1;
            case (r.kind)
              K_DEV: begin
                if (r.sh[7:1] == {DEV_ADDR_HI, r.strap_s[1]}) begin
                  n.rw   = r.sh[0];
                  n.kind = r.sh[0] ? K_DAT : K_REG;
                end else begin
                  n.st     = S_IDLE;
                  n.sda_oe = 1'b0;
                end
              end
              K_REG: begin
                n.ptr  = r.sh;
                n.kind = K_DAT;
              end
              default: begin
                // A full buffer refuses the byte with no acknowledge
                if (buf_ready) begin
                  n.push = 1'b1;
                  n.wdat = {r.ptr, r.sh};
                  n.ptr  = ptr_step(r.ptr);
                end else begin
                  n.st     = S_IDLE;
                  n.sda_oe = 1'b0;
                end
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            if (r.rw) begin
              n.st     = S_TX;
              n.sh     = RD_DATA_I;
              n.sda_oe = ~RD_DATA_I[7];
            end else begin
              n.st = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (r.bitcnt == BITS_PER_BYTE - 4'h1) begin
              n.sda_oe = 1'b0;
              n.st     = S_RACK;
              n.bitcnt = '0;
              n.ptr    = ptr_step(r.ptr);
            end else begin
              n.sh     = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6];
              n.bitcnt = r.bitcnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            n.hack = ~r.sda_f;
          end else if (scl_fall) begin
            // A missing acknowledge marks the last read byte
            if (r.hack) begin
              n.st     = S_TX;
              n.sh     = RD_DATA_I;
              n.sda_oe = ~RD_DATA_I[7];
            end else begin
              n.st = S_IDLE;
            end
          end
        end
        default: begin
          n.st = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r <= D_RST;
    end else begin
      r <= n;
    end
  end
endmodule // cfgss_dev

// ==== cfgss_pkg.sv ====
// Constants shared by both ends of the configuration serial link
// Notes on behaviour
// - Data line is only pulled low or released
// - Host alone drives the serial clock
// - Upper six address bits fixed at 100110
// - Address low bit follows the strap pin
// - Host opens transfers with a start condition
// - Device ignores traffic until a start
// - Direction bit: one reads, zero writes
// - Device acknowledges its own address
// - One or more bytes follow an acknowledged address
// - Stop ends the transfer, device waits again
// - Repeated start begins a new addressed phase
// - First written byte loads the register pointer
// - Pointer increments after every acknowledged data byte
// - Reads return pointer register, then pointer advances
// - Data stable while clock high, except conditions
// - Clock deglitched over three reference periods
// - Written bits captured on delayed rising edge
// - Read data changes after delayed falling edge
package cfgss_pkg;
  localparam logic [5:0] DEV_ADDR_HI     = 6'h26;
  localparam int         DEGLITCH_CYC    = 3;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [7:0] PTR_RESET       = 8'h00;
  localparam int         CORE_PERIOD_NS  = 10;
  localparam int         SCL_PERIOD_NS   = 400;
  localparam int         SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);
  localparam int         WR_WORD_W       = 16;
  localparam int         WR_BUF_DEPTH    = 2;
endpackage

// ==== cfgss_if.sv ====
// Two-wire link between host end and device end
`timescale 1ns/10ps
interface cfgss_if;
  logic scl;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic sda;

  // Open-drain wire: low while either end pulls, pulled up otherwise
  assign sda = ~(sda_oe_host | sda_oe_dev);

  modport host (output scl, output sda_oe_host, input sda);
  modport dev  (input scl, input sda, output sda_oe_dev);
endinterface

// ==== cfgss_buf.sv ====
// Small shift-style buffer with valid and ready on both sides
`timescale 1ns/10ps
module cfgss_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
    logic                    nz;
    logic                    full;
  } cfgss_buf_t;

  cfgss_buf_t r, n;
  logic       push;
  logic       pop;
  logic [CW-1:0] wi;

  assign in_ready_o  = ~r.full;
  assign out_valid_o = r.nz;
  assign out_data_o  = r.mem[0];
  assign push        = in_valid_i & ~r.full;
  assign pop         = r.nz & out_ready_i;
  assign wi          = r.cnt - {{(CW-1){1'b0}}, pop};

  // Head entry always sits in mem[0] so the output is a plain register
  always_comb begin
    n = r;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        n.mem[i] = r.mem[i+1];
      end
    end
    if (push) begin
      n.mem[wi] = in_data_i;
    end
    n.cnt  = wi + {{(CW-1){1'b0}}, push};
    n.nz   = (n.cnt != '0);
    n.full = (n.cnt == CW'(DEPTH));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // cfgss_buf

// ==== cfgss_host.sv ====
// Host end: bus master issuing byte commands over the two-wire link
`timescale 1ns/10ps
module cfgss_host
  import cfgss_pkg::*;
#(
  parameter int QUARTER_CYC = SCL_QUARTER_CYC
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_I,
  cfgss_if.host           bus,
  input  wire logic       CMD_VALID_I,
  output logic            CMD_READY_O,
  input  wire logic       CMD_START_I,
  input  wire logic       CMD_STOP_I,
  input  wire logic       CMD_READ_I,
  input  wire logic       CMD_LAST_I,
  input  wire logic [7:0] CMD_DATA_I,
  output logic            RSP_VALID_O,
  output logic [7:0]      RSP_DATA_O,
  output logic            RSP_ACK_O
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} cfgss_hst_t;

  typedef struct packed {
    cfgss_hst_t st;
    logic [7:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic       rd;
    logic       last;
    logic       stop;
    logic       scl;
    logic       sda_oe;
    logic [1:0] sda_s;
    logic       ready;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       rsp_ack;
  } cfgss_hreg_t;

  localparam cfgss_hreg_t H_RST = '{st: H_IDLE, scl: 1'b1, ready: 1'b1, default: '0};
  localparam logic [7:0]  Q_LAST = 8'(QUARTER_CYC - 1);

  cfgss_hreg_t r, n;
  logic        tick;

  assign tick            = (r.cnt == Q_LAST);
  assign bus.scl         = r.scl;
  assign bus.sda_oe_host = r.sda_oe;
  assign CMD_READY_O     = r.ready;
  assign RSP_VALID_O     = r.rsp_valid;
  assign RSP_DATA_O      = r.rsp_data;
  assign RSP_ACK_O       = r.rsp_ack;

  always_comb begin
    n           = r;
    n.rsp_valid = 1'b0;
    n.sda_s     = {r.sda_s[0], bus.sda};
    n.cnt       = tick ? 8'h00 : r.cnt + 8'h01;
    case (r.st)
      H_IDLE: begin
        if (CMD_VALID_I) begin
          n.sh     = CMD_DATA_I;
          n.rd     = CMD_READ_I;
          n.last   = CMD_LAST_I;
          n.stop   = CMD_STOP_I;
          n.ph     = 2'h0;
          n.bitcnt = '0;
          n.st     = CMD_START_I ? H_START : H_BIT;
        end
      end
      H_START: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          case (r.ph)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl    = 1'b1;
            2'h2: n.sda_oe = 1'b1;
            default: begin
              n.scl = 1'b0;
              n.st  = H_BIT;
            end
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          case (r.ph)
            2'h0: begin
              // Data moves only while the clock is low
              if (r.bitcnt == BITS_PER_BYTE) begin
                n.sda_oe = r.rd & ~r.last;
              end else begin
                n.sda_oe = ~r.rd & ~r.sh[7];
              end
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (r.bitcnt == BITS_PER_BYTE) begin
                n.rsp_ack = r.rd | ~r.sda_s[1];
              end else begin
                n.sh = {r.sh[6:0], r.sda_s[1]};
              end
            end
            default: begin
              n.scl = 1'b0;
              if (r.bitcnt == BITS_PER_BYTE) begin
                n.rsp_data = r.sh;
                if (r.stop) begin
                  n.st = H_STOP;
                end else begin
                  n.st        = H_IDLE;
                  n.rsp_valid = 1'b1;
                end
              end else begin
                n.bitcnt = r.bitcnt + 4'h1;
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          n.ph = r.ph + 2'h1;
          case (r.ph)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl    = 1'b1;
            2'h2: n.sda_oe = 1'b0;
            default: begin
              n.st        = H_IDLE;
              n.rsp_valid = 1'b1;
            end
          endcase
        end
      end
    endcase
    n.ready = (n.st == H_IDLE) & ~(r.st == H_IDLE & CMD_VALID_I);
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r <= H_RST;
    end else begin
      r <= n;
    end
  end
endmodule // cfgss_host

// ==== cfgss_asserts.sv ====
// Checker watching the two-wire link between host end and device end
`timescale 1ns/10ps
module cfgss_asserts (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic scl,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic sda
);
  logic       scl_q_r;
  logic       sda_q_r;
  logic       frame_r;
  logic [4:0] fall_cnt_r;

  // Cycles since the last falling clock edge, saturating
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
      frame_r    <= 1'b0;
      fall_cnt_r <= 5'h1f;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      if (scl && sda_q_r && !sda) begin
        frame_r <= 1'b1;
      end else if (scl && !sda_q_r && sda) begin
        frame_r <= 1'b0;
      end
      if (scl_q_r && !scl) begin
        fall_cnt_r <= 5'h00;
      end else if (fall_cnt_r != 5'h1f) begin
        fall_cnt_r <= fall_cnt_r + 5'h01;
      end
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  sequence dev_bit_slot;
    $rose(scl) && sda_oe_dev;
  endsequence
  sequence dev_bit_held;
    sda_oe_dev[*8];
  endsequence

  a_wire_open_drain: assert property ((sda_oe_host || sda_oe_dev) |-> !sda)
    else $error("data line high while pulled");
  a_clk_high_len: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  a_clk_low_len: assert property ($fell(scl) |-> (!scl)[*8])
    else $error("clock low phase too short");
  a_dev_changes_low: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("device moved data while clock high");
  a_dev_after_fall: assert property ($changed(sda_oe_dev) |-> fall_cnt_r inside {[3:10]})
    else $error("device data change not delayed after clock fall");
  a_start_by_host: assert property (scl && $fell(sda) |-> sda_oe_host)
    else $error("start condition not made by host");
  a_dev_bit_held: assert property (dev_bit_slot |-> dev_bit_held)
    else $error("device bit not held through clock high");
  a_idle_silent: assert property (!frame_r |-> !sda_oe_dev)
    else $error("device drives outside a transfer");
endmodule // cfgss_asserts

// ==== config_register_serial_slave_test.sv ====
// Testbench joining host end and device end over the two-wire link
`timescale 1ns/10ps
module config_register_serial_slave_test
  import cfgss_pkg::*;
;
  logic        core_clk;
  logic        rst;
  logic        strap;
  logic        wr_valid;
  logic        wr_ready;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        c_valid;
  logic        c_ready;
  logic        c_start;
  logic        c_stop;
  logic        c_read;
  logic        c_last;
  logic [7:0]  c_data;
  logic        r_valid;
  logic [7:0]  r_data;
  logic        r_ack;
  logic [15:0] words[$];
  int          error_cnt;
  int          tests_run;
  int          cyc;

  cfgss_if link();
  cfgss_host #(.QUARTER_CYC(8)) u_cfgss_host (
    .CORE_CLK_I(core_clk), .RST_I(rst), .bus(link.host), .CMD_VALID_I(c_valid),
    .CMD_READY_O(c_ready), .CMD_START_I(c_start), .CMD_STOP_I(c_stop),
    .CMD_READ_I(c_read), .CMD_LAST_I(c_last), .CMD_DATA_I(c_data),
    .RSP_VALID_O(r_valid), .RSP_DATA_O(r_data), .RSP_ACK_O(r_ack));
  cfgss_dev u_cfgss_dev (
    .CORE_CLK_I(core_clk), .RST_I(rst), .bus(link.dev), .BUS_ADDR_STRAP_I(strap),
    .WR_VALID_O(wr_valid), .WR_READY_I(wr_ready), .WR_ADDR_O(wr_addr),
    .WR_DATA_O(wr_data), .RD_ADDR_O(rd_addr), .RD_DATA_I(rd_data));
  cfgss_asserts u_cfgss_asserts (
    .CORE_CLK_I(core_clk), .RST_I(rst), .scl(link.scl), .sda_oe_host(link.sda_oe_host),
    .sda_oe_dev(link.sda_oe_dev), .sda(link.sda));

  // Register file stand-in: each register reads as its inverted address
  assign rd_data = ~rd_addr;

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) begin
      words.push_back({wr_addr, wr_data});
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One byte command; waits for its response pulse
  task automatic cmd(input logic st, input logic sp, input logic rd, input logic ls,
                     input logic [7:0] d);
    @(negedge core_clk);
    while (c_ready !== 1'b1) begin
      @(negedge core_clk);
    end
    c_valid = 1'b1;
    c_start = st;
    c_stop  = sp;
    c_read  = rd;
    c_last  = ls;
    c_data  = d;
    @(negedge core_clk);
    c_valid = 1'b0;
    while (r_valid !== 1'b1) begin
      @(negedge core_clk);
    end
  endtask

  task automatic t_write;
    words.delete();
    cmd(1, 0, 0, 0, 8'h98);
    chk("addr ack", 16'h1, r_ack);
    cmd(0, 0, 0, 0, 8'h05);
    chk("ptr ack", 16'h1, r_ack);
    cmd(0, 0, 0, 0, 8'hab);
    chk("first data ack", 16'h1, r_ack);
    cmd(0, 1, 0, 0, 8'hcd);
    chk("data ack", 16'h1, r_ack);
    chk("write echo", 16'h00cd, r_data);
    repeat (20) @(negedge core_clk);
    chk("word count", 16'h2, 16'(words.size()));
    chk("first word", 16'h05ab, words.pop_front());
    chk("second word", 16'h06cd, words.pop_front());
  endtask

  task automatic t_addr;
    logic [7:0] a[4] = '{8'h98, 8'h9a, 8'h9c, 8'h18};
    for (int s = 0; s < 2; s++) begin
      strap = s[0];
      repeat (10) @(negedge core_clk);
      for (int i = 0; i < 4; i++) begin
        cmd(1, 1, 0, 0, a[i]);
        chk("addr match", {15'h0, a[i][7:1] == {DEV_ADDR_HI, s[0]}}, r_ack);
      end
    end
  endtask

  task automatic t_read;
    cmd(1, 0, 0, 0, {DEV_ADDR_HI, 1'b1, 1'b0});
    cmd(0, 0, 0, 0, 8'h10);
    cmd(1, 0, 0, 0, {DEV_ADDR_HI, 1'b1, 1'b1});
    chk("read ack", 16'h1, r_ack);
    cmd(0, 0, 1, 0, 8'h00);
    chk("read first", 16'h00ef, r_data);
    cmd(0, 1, 1, 1, 8'h00);
    chk("read second", 16'h00ee, r_data);
    chk("pointer", 16'h0012, rd_addr);
  endtask

  // Receiver stalls: bytes beyond the buffer are refused, none is lost
  task automatic t_stall;
    int acks;
    acks = 0;
    words.delete();
    wr_ready = 1'b0;
    cmd(1, 0, 0, 0, {DEV_ADDR_HI, 1'b1, 1'b0});
    cmd(0, 0, 0, 0, 8'h40);
    for (int i = 0; i < 4; i++) begin
      cmd(0, i == 3, 0, 0, 8'h60 + i[7:0]);
      if (r_ack === 1'b1 && acks == i) begin
        acks++;
      end
    end
    chk("stall accepted", WR_BUF_DEPTH[15:0], acks[15:0]);
    chk("kept pointer", 16'h0040 + WR_BUF_DEPTH[15:0], {8'h00, rd_addr});
    wr_ready = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("drained count", acks[15:0], 16'(words.size()));
    for (int j = 0; j < acks; j++) begin
      chk("drained word", {8'h40 + j[7:0], 8'h60 + j[7:0]}, words.pop_front());
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    rst      = 1'b1;
    strap    = 1'b0;
    wr_ready = 1'b1;
    c_valid  = 1'b0;
    c_start  = 1'b0;
    c_stop   = 1'b0;
    c_read   = 1'b0;
    c_last   = 1'b0;
    c_data   = 8'h00;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    // Bus left idle while the device's filtered view settles
    repeat (12) @(negedge core_clk);
    t_write();
    t_addr();
    t_read();
    t_stall();
    conclude();
  end
endmodule // config_register_serial_slave_test
